// [verilog/smc_defs.svh]
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// Sleep mode selection codes.
`define SMC_MODE_NORMAL 4'h0
`define SMC_MODE_PIN 4'h1
`define SMC_MODE_CYC 4'h4
`define SMC_MODE_CYC_PIN 4'h5
`define SMC_MODE_SUPPORT 4'h7
`define SMC_MODE_SYNC_CYC 4'h8

// Timing: one tick of the sleep and wake settings, in nanoseconds.
`define SMC_CLK_PERIOD_NS 10
`define SMC_TICK_NS 1000000
`define SMC_TICK_CYCLES (`SMC_TICK_NS / `SMC_CLK_PERIOD_NS)

// Length of the brief poll window of a cyclic waker, in ticks.
`define SMC_BRIEF_WAKE_TICKS 16'h0001

// Reset values of the network sleep and wake times, in ticks.
`define SMC_NET_SLEEP_RST 16'h0064
`define SMC_NET_WAKE_RST 16'h0010

`endif

// [verilog/smc_pkg.sv]
package smc_pkg;

    // Power and phase states of the controller.
    typedef enum logic [1:0] {
        smc_st_on,
        smc_st_drain,
        smc_st_sleep,
        smc_st_wake
    } smc_state_e;

endpackage

// [verilog/smc_tmr_if.sv]
`timescale 1ns/1ps

// Control path between the sequencer and its tick timer.
interface smc_tmr_if #(
    parameter int TW = 16
);
    logic load;
    logic [TW-1:0] load_val;
    logic expired;

    modport ctl (output load, output load_val, input expired);
    modport tmr (input load, input load_val, output expired);
endinterface

// [verilog/smc_timer.sv]
`timescale 1ns/1ps
`include "smc_defs.svh"

// Down counter of ticks with a cycle prescaler.
module smc_timer #(
    parameter int TW = 16,
    parameter int TICK_CYCLES = `SMC_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    smc_tmr_if.tmr tif
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_MAX = PW'(TICK_CYCLES - 1);

    logic [PW-1:0] pre_ff;
    logic [TW-1:0] cnt_ff;
    logic run_ff;
    logic expired_ff;
    logic tick;

    assign tick = (pre_ff == PRE_MAX);
    assign tif.expired = expired_ff;

    // ----------------------------------------------------------------
    // Prescaler: a load restarts it so a period starts on a full tick.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_ff <= '0;
        end else if (tif.load || tick) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + PW'(1);
        end
    end

    // ----------------------------------------------------------------
    // Tick counter: a zero load is treated as one tick.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            expired_ff <= 1'b0;
        end else begin
            expired_ff <= 1'b0;
            if (tif.load) begin
                cnt_ff <= (tif.load_val == '0) ? TW'(1) : tif.load_val;
                run_ff <= 1'b1;
            end else if (run_ff && tick) begin
                if (cnt_ff == TW'(1)) begin
                    run_ff <= 1'b0;
                    expired_ff <= 1'b1;
                end
                cnt_ff <= cnt_ff - TW'(1);
            end
        end
    end
endmodule

// [verilog/smc_top.sv]
// Functional notes
// (RULE_01) Mode 0 stays awake always.
// (RULE_02) Mode 0 relays sync, never originates it.
// (RULE_03) Mode 1 finishes traffic before sleeping.
// (RULE_04) Mode 1 wakes when doze request falls.
// (RULE_05) Async wake sends poll when polling enabled.
// (RULE_06) Mode 4 sleeps, wakes briefly, resleeps idle.
// (RULE_07) Async cyclic awake indicator follows awake state.
// (RULE_08) Flow control: CTS low awake, high asleep.
// (RULE_09) Mode 5 cycles while held, wakes on release.
// (RULE_10) Mode 5 never sleeps while request released.
// (RULE_11) Mode 7 never sleeps, answers joins with sync.
// (RULE_12) Support node sends data only in wake.
// (RULE_13) Mode 8 sleeps, wakes in unison, resleeps.
// (RULE_14) Sync sleeper ignores radio and serial asleep.
// (RULE_15) Local timing used only until synchronized.
// (RULE_16) Awake indicator enabled follows awake state.
// (RULE_17) CTS held deasserted while sync sleeper sleeps.
// (RULE_18) Unsynced sleeper listens then sleeps, repeating.
// (RULE_19) Modes 4/5 data starts or restarts wake timer.
// (RULE_20) Wake timer expiry returns to sleep.
// (RULE_21) Coordinator sends one sync per wake; others relay.
// (RULE_22) Latest local timing change becomes network timing.
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_top
    import smc_pkg::*;
#(
    parameter int TW = 16,
    parameter int TICK_CYCLES = `SMC_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] sleep_mode_select,
    input wire logic [TW-1:0] wake_time,
    input wire logic [TW-1:0] sleep_period,
    input wire logic doze_request_pin,
    input wire logic cts_flow_enable,
    input wire logic awake_indicator_enable,
    input wire logic poll_enable,
    input wire logic sleep_coordinator,
    input wire logic settings_changed,
    input wire logic serial_rx_activity,
    input wire logic rf_rx_activity,
    input wire logic tx_busy,
    input wire logic rx_busy,
    input wire logic sync_rx_valid,
    input wire logic [TW-1:0] sync_rx_sleep,
    input wire logic [TW-1:0] sync_rx_wake,
    input wire logic join_request,
    output logic radio_on_ff,
    output logic host_accept_ff,
    output logic awake_ind_ff,
    output logic cts_n_ff,
    output logic poll_req_ff,
    output logic sync_tx_ff,
    output logic sync_relay_ff,
    output logic data_tx_ok_ff,
    output logic synced_ff,
    output logic [TW-1:0] synced_sleep_time_query_ff,
    output logic [TW-1:0] synced_wake_time_query_ff
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    // Control path to the tick timer.
    smc_tmr_if #(.TW(TW)) tif ();

    // Sequencer state and decoded mode.
    smc_state_e state_ff;
    smc_state_e nxt_state;
    logic [3:0] mode_ff;
    logic [TW-1:0] net_sleep_ff;
    logic [TW-1:0] net_wake_ff;
    logic [TW-1:0] sleep_len;
    logic [TW-1:0] wake_len;
    logic mode_chg;
    logic is_async_cyc;
    logic is_sync;
    logic tracks_net;
    logic data_in;
    logic awake_now;
    logic nxt_awake;
    logic wake_start;
    logic sync_heard;
    logic nxt_load;
    logic [TW-1:0] nxt_load_val;

    // ----------------------------------------------------------------
    // Mode decode.
    // ----------------------------------------------------------------
    assign mode_chg = (sleep_mode_select != mode_ff);
    assign is_async_cyc = (mode_ff == `SMC_MODE_CYC) ||
                          (mode_ff == `SMC_MODE_CYC_PIN);
    assign is_sync = (mode_ff == `SMC_MODE_SUPPORT) ||
                     (mode_ff == `SMC_MODE_SYNC_CYC);
    assign tracks_net = is_sync || (mode_ff == `SMC_MODE_NORMAL);
    assign data_in = serial_rx_activity || rf_rx_activity;

    // Local timing until synced, then the network's timing.
    assign sleep_len = synced_ff ? net_sleep_ff : sleep_period; // see RULE_15
    assign wake_len = synced_ff ? net_wake_ff : wake_time; // see RULE_15

    // Support and normal nodes never power down with the network phase.
    assign awake_now = (state_ff != smc_st_sleep) ||
                       (mode_ff == `SMC_MODE_SUPPORT) || // see RULE_11
                       (mode_ff == `SMC_MODE_NORMAL); // see RULE_01

    // A sync is only heard while the radio is powered.
    assign sync_heard = sync_rx_valid && awake_now &&
                        tracks_net && !mode_chg; // see RULE_14

    // ----------------------------------------------------------------
    // Sequencer: next state and timer loads.
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_load = 1'b0;
        nxt_load_val = '0;
        // A mode change always restarts from the awake state.
        if (mode_chg) begin
            nxt_state = smc_st_on;
        end else begin
            unique case (state_ff)
                // Awake: each mode but mode 0 takes its own road into sleep.
                smc_st_on: begin
                    if (mode_ff == `SMC_MODE_PIN && doze_request_pin) begin
                        nxt_state = smc_st_drain; // see RULE_03
                    end else if (mode_ff == `SMC_MODE_CYC ||
                                 (mode_ff == `SMC_MODE_CYC_PIN &&
                                  doze_request_pin)) begin
                        nxt_state = smc_st_sleep; // see RULE_09
                        nxt_load = 1'b1;
                        nxt_load_val = sleep_period; // see RULE_06
                    end else if (is_sync) begin
                        nxt_state = smc_st_wake; // see RULE_18
                        nxt_load = 1'b1;
                        nxt_load_val = wake_len;
                    end
                end
                // Draining: wait for the radio to fall idle.
                smc_st_drain: begin
                    if (!doze_request_pin) begin
                        nxt_state = smc_st_on; // see RULE_04
                    end else if (!tx_busy && !rx_busy) begin
                        nxt_state = smc_st_sleep; // see RULE_03
                    end
                end
                // Asleep: a pin release or timer expiry wakes.
                smc_st_sleep: begin
                    if (mode_ff == `SMC_MODE_PIN ||
                        mode_ff == `SMC_MODE_CYC_PIN) begin
                        if (!doze_request_pin) begin
                            nxt_state = smc_st_on; // see RULE_04, RULE_10
                        end else if (is_async_cyc && tif.expired) begin
                            nxt_state = smc_st_wake;
                            nxt_load = 1'b1;
                            nxt_load_val = TW'(`SMC_BRIEF_WAKE_TICKS);
                        end
                    end else if (tif.expired) begin
                        nxt_state = smc_st_wake; // see RULE_06, RULE_13
                        nxt_load = 1'b1;
                        nxt_load_val = is_sync ? wake_len :
                                       TW'(`SMC_BRIEF_WAKE_TICKS);
                    end
                end
                // Wake window: sync realigns, data extends it.
                smc_st_wake: begin
                    if (mode_ff == `SMC_MODE_CYC_PIN &&
                        !doze_request_pin) begin
                        nxt_state = smc_st_on; // see RULE_09
                    end else if (sync_heard && is_sync) begin
                        // Realign the wake window to the sender.
                        nxt_load = 1'b1;
                        nxt_load_val = sync_rx_wake;
                    end else if (is_async_cyc && data_in) begin
                        nxt_load = 1'b1;
                        nxt_load_val = wake_time; // see RULE_19
                    end else if (tif.expired) begin
                        nxt_state = smc_st_sleep; // see RULE_20
                        nxt_load = 1'b1;
                        nxt_load_val = is_sync ? sleep_len :
                                       sleep_period; // see RULE_18
                    end
                end
                default: begin
                    nxt_state = smc_st_on;
                end
            endcase
        end
    end

    // The tick timer is loaded as the sequencer decides.
    assign tif.load = nxt_load;
    assign tif.load_val = nxt_load_val;

    // Awake level after this edge, used for every powered output.
    always_comb begin
        if (mode_chg) begin
            nxt_awake = 1'b1;
        end else begin
            nxt_awake = (nxt_state != smc_st_sleep) ||
                        (mode_ff == `SMC_MODE_SUPPORT) ||
                        (mode_ff == `SMC_MODE_NORMAL);
        end
    end

    // Start of a network wake period after a sleep period.
    assign wake_start = is_sync && !mode_chg &&
                        (state_ff == smc_st_sleep) &&
                        (nxt_state == smc_st_wake);

    // ----------------------------------------------------------------
    // State and mode registers.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= smc_st_on;
            mode_ff <= `SMC_MODE_NORMAL;
        end else begin
            state_ff <= nxt_state;
            // The mode input is registered every edge.
            mode_ff <= sleep_mode_select;
        end
    end

    // ----------------------------------------------------------------
    // Network synchronization and shared timing.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            synced_ff <= 1'b0;
            net_sleep_ff <= TW'(`SMC_NET_SLEEP_RST);
            net_wake_ff <= TW'(`SMC_NET_WAKE_RST);
        end else begin
            // Leaving the sync-tracking modes forgets the sync.
            if (!tracks_net) begin
                synced_ff <= 1'b0;
            end else if (sync_heard) begin
                synced_ff <= 1'b1;
            end
            // A local change is the newest setting and wins.
            if (settings_changed) begin
                net_sleep_ff <= sleep_period; // see RULE_22
                net_wake_ff <= wake_time; // see RULE_22
            end else if (sync_heard) begin
                net_sleep_ff <= sync_rx_sleep; // see RULE_15
                net_wake_ff <= sync_rx_wake;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sync message origination and relay.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_tx_ff <= 1'b0;
            sync_relay_ff <= 1'b0;
        end else begin
            // One sync per wake period, or a reply to a joiner.
            sync_tx_ff <= (wake_start && sleep_coordinator) || // see RULE_21
                          (mode_ff == `SMC_MODE_SUPPORT && !mode_chg &&
                           synced_ff && join_request); // see RULE_11
            // Normal nodes relay but never originate.
            sync_relay_ff <= sync_heard &&
                             !(sleep_coordinator && is_sync); // see RULE_02
        end
    end

    // ----------------------------------------------------------------
    // Host side: power, indicator, flow control, poll.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            radio_on_ff <= 1'b1;
            host_accept_ff <= 1'b1;
            awake_ind_ff <= 1'b0;
            cts_n_ff <= 1'b0;
            poll_req_ff <= 1'b0;
        end else begin
            // Powered outputs follow the awake level.
            radio_on_ff <= nxt_awake; // see RULE_01, RULE_13
            host_accept_ff <= nxt_awake; // see RULE_14
            if (sleep_mode_select == `SMC_MODE_CYC ||
                sleep_mode_select == `SMC_MODE_CYC_PIN) begin
                awake_ind_ff <= nxt_awake; // see RULE_07
            end else begin
                awake_ind_ff <= awake_indicator_enable &&
                                nxt_awake; // see RULE_16
            end
            // Active-low CTS: high only when asleep with flow control.
            cts_n_ff <= cts_flow_enable &&
                        !nxt_awake; // see RULE_08, RULE_17
            poll_req_ff <= poll_enable && !mode_chg && nxt_awake &&
                           !awake_now &&
                           (mode_ff == `SMC_MODE_PIN ||
                            is_async_cyc); // see RULE_05
        end
    end

    // ----------------------------------------------------------------
    // Data gating and timing query values.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_tx_ok_ff <= 1'b1;
            synced_sleep_time_query_ff <= '0;
            synced_wake_time_query_ff <= '0;
        end else begin
            if (mode_chg) begin
                data_tx_ok_ff <= 1'b0;
            end else if (is_sync) begin
                // Network phase gates data on sync nodes.
                data_tx_ok_ff <= (nxt_state == smc_st_wake); // see RULE_12
            end else if (mode_ff == `SMC_MODE_NORMAL) begin
                data_tx_ok_ff <= 1'b1; // see RULE_02
            end else begin
                data_tx_ok_ff <= nxt_awake;
            end
            // Time queries read zero until synchronized.
            synced_sleep_time_query_ff <= synced_ff ? net_sleep_ff : '0;
            synced_wake_time_query_ff <= synced_ff ? net_wake_ff : '0;
        end
    end

    // ----------------------------------------------------------------
    // Tick timer for sleep and wake periods.
    // ----------------------------------------------------------------
    smc_timer #(
        .TW(TW),
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tif(tif.tmr)
    );

endmodule

// [dv/smc_top_monitor.sv]
`timescale 1ns/1ps

// Port checker for the sleep controller, attached by bind.
module smc_top_monitor (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] sleep_mode_select,
    input wire logic doze_request_pin,
    input wire logic cts_flow_enable,
    input wire logic poll_enable,
    input wire logic tx_busy,
    input wire logic rx_busy,
    input wire logic radio_on_ff,
    input wire logic awake_ind_ff,
    input wire logic cts_n_ff,
    input wire logic poll_req_ff,
    input wire logic sync_tx_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // A mode held long enough for the sequencer to settle.
    sequence s_mode(logic [3:0] m);
        (sleep_mode_select == m)[*4];
    endsequence

    // Pin sleep mode selected while the radio is still busy.
    sequence s_busy;
        (sleep_mode_select == 4'h1 && radio_on_ff && (tx_busy || rx_busy))[*2];
    endsequence

    a_normal_awake: assert property (
        s_mode(4'h0) |-> radio_on_ff)
        else $error("Normal mode dropped the radio.");
    a_normal_no_sync: assert property (
        s_mode(4'h0) |-> !sync_tx_ff)
        else $error("Normal mode originated a sync.");
    a_drain_busy: assert property (
        s_busy |=> radio_on_ff)
        else $error("Slept while traffic was in progress.");
    a_pin_wake: assert property (
        sleep_mode_select == 4'h1 && !doze_request_pin && !radio_on_ff
        |-> ##[1:2] radio_on_ff)
        else $error("Pin release did not wake the radio.");
    a_poll_wake: assert property (
        $rose(radio_on_ff) && poll_enable && sleep_mode_select == 4'h1
        |-> ##[0:1] poll_req_ff)
        else $error("No poll after waking.");
    a_ind_cyclic: assert property (
        s_mode(4'h4) |-> awake_ind_ff == radio_on_ff)
        else $error("Awake indicator differs from radio state.");
    a_cts_asleep: assert property (
        cts_n_ff |-> !radio_on_ff)
        else $error("Clear-to-send withdrawn while awake.");
    a_cts_held: assert property (
        !radio_on_ff && !$past(radio_on_ff) && cts_flow_enable |-> cts_n_ff)
        else $error("Clear-to-send offered while asleep.");
    a_support_awake: assert property (
        s_mode(4'h7) |-> radio_on_ff)
        else $error("Support mode dropped the radio.");
    a_pin5_awake: assert property (
        (sleep_mode_select == 4'h5 && !doze_request_pin)[*3] |-> radio_on_ff)
        else $error("Slept with the doze request released.");
endmodule

// [dv/smc_host_model.sv]
`timescale 1ns/1ps

// Host side: drives the doze request and sends serial bytes.
module smc_host_model (
    input wire logic ref_clk,
    input wire logic cts_n_ff,
    input wire logic want_sleep,
    input wire logic want_send,
    output logic doze_request_pin,
    output logic serial_rx_activity
);
    logic sleep_q = 1'b0;
    logic send_q = 1'b0;

    // Commands are taken on the rising edge to avoid a race with the bench.
    always @(posedge ref_clk) begin
        sleep_q <= want_sleep;
        send_q <= want_send;
    end

    // Pins change on the falling edge; bytes wait for clear-to-send.
    always @(negedge ref_clk) begin
        doze_request_pin <= sleep_q;
        serial_rx_activity <= send_q && !cts_n_ff;
    end

    // Idle levels before the first falling edge.
    initial begin
        doze_request_pin = 1'b0;
        serial_rx_activity = 1'b0;
    end
endmodule

// [dv/smc_top_tb_top.sv]
`timescale 1ns/1ps

module smc_top_tb_top;
    localparam int TK = 4;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] sleep_mode_select = 4'h0;
    logic [15:0] wake_time = 16'h0005;
    logic [15:0] sleep_period = 16'h0003;
    logic [15:0] sync_rx_sleep = 16'h0000;
    logic [15:0] sync_rx_wake = 16'h0000;
    logic cts_flow_enable = 1'b1;
    logic awake_indicator_enable = 1'b1;
    logic poll_enable = 1'b0;
    logic sleep_coordinator = 1'b0;
    logic settings_changed = 1'b0;
    logic rf_rx_activity = 1'b0;
    logic tx_busy = 1'b0;
    logic rx_busy = 1'b0;
    logic sync_rx_valid = 1'b0;
    logic join_request = 1'b0;
    logic want_sleep = 1'b0;
    logic want_send = 1'b0;
    logic doze_request_pin, serial_rx_activity;
    logic radio_on_ff, host_accept_ff, awake_ind_ff, cts_n_ff, poll_req_ff;
    logic sync_tx_ff, sync_relay_ff, data_tx_ok_ff, synced_ff;
    logic [15:0] synced_sleep_time_query_ff, synced_wake_time_query_ff;
    int n_fail = 0, checked = 0, n_poll = 0, n_tx = 0, n_relay = 0;
    int cnt = 0, ok_hi = 0, ok_lo = 0;

    smc_top #(.TW(16), .TICK_CYCLES(TK)) i_dut (.ref_clk, .sys_rst,
        .sleep_mode_select, .wake_time, .sleep_period, .doze_request_pin,
        .cts_flow_enable, .awake_indicator_enable, .poll_enable,
        .sleep_coordinator, .settings_changed, .serial_rx_activity,
        .rf_rx_activity, .tx_busy, .rx_busy, .sync_rx_valid, .sync_rx_sleep,
        .sync_rx_wake, .join_request, .radio_on_ff, .host_accept_ff,
        .awake_ind_ff, .cts_n_ff, .poll_req_ff, .sync_tx_ff, .sync_relay_ff,
        .data_tx_ok_ff, .synced_ff, .synced_sleep_time_query_ff,
        .synced_wake_time_query_ff);

    smc_host_model i_host (.ref_clk, .cts_n_ff, .want_sleep, .want_send,
        .doze_request_pin, .serial_rx_activity);

    // Free-running 100 MHz clock.
    always #5 ref_clk = ~ref_clk;

    // Tally the one-cycle pulses of the controller.
    always @(posedge ref_clk) begin
        if (poll_req_ff === 1'b1) n_poll++;
        if (sync_tx_ff === 1'b1) n_tx++;
        if (sync_relay_ff === 1'b1) n_relay++;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Waits for the radio state with a bound; cnt holds the cycles spent.
    task automatic wait_radio(input logic v, input int lim);
        cnt = 0;
        while (radio_on_ff !== v) begin
            @(negedge ref_clk);
            cnt++;
            if (cnt > lim) begin
                n_fail++;
                $display("BAD %0t radio wait ran out", $time);
                final_report();
            end
        end
    endtask

    task automatic send_sync(input logic [15:0] s, input logic [15:0] w);
        sync_rx_sleep = s;
        sync_rx_wake = w;
        sync_rx_valid = 1'b1;
        cyc(1);
        sync_rx_valid = 1'b0;
    endtask

    task automatic send_byte();
        want_send = 1'b1;
        cyc(1);
        want_send = 1'b0;
    endtask

    // Main sequence: one block per sleep mode.
    initial begin
        cyc(3);
        sys_rst = 1'b0;
        cyc(10);
        send_sync(16'h0005, 16'h0003);
        cyc(6);
        send_sync(16'h0005, 16'h0003);
        cyc(4);
        chk(16'(radio_on_ff), 16'h1);
        chk(16'(n_relay >= 1), 16'h1);
        chk(16'(n_tx), 16'h0);
        $display("done normal");
        sleep_mode_select = 4'h1;
        poll_enable = 1'b1;
        tx_busy = 1'b1;
        cyc(4);
        want_sleep = 1'b1;
        cyc(12);
        chk(16'(radio_on_ff), 16'h1);
        tx_busy = 1'b0;
        rx_busy = 1'b1;
        cyc(6);
        chk(16'(radio_on_ff), 16'h1);
        rx_busy = 1'b0;
        wait_radio(1'b0, 6);
        chk(16'(cts_n_ff), 16'h1);
        n_poll = 0;
        want_sleep = 1'b0;
        wait_radio(1'b1, 6);
        cyc(3);
        chk(16'(n_poll), 16'h1);
        chk(16'(cts_n_ff), 16'h0);
        poll_enable = 1'b0;
        $display("done pin sleep");
        sleep_mode_select = 4'h4;
        wait_radio(1'b0, 20);
        wait_radio(1'b1, 30);
        chk(16'(cnt >= 3 * TK && cnt <= 3 * TK + 3), 16'h1);
        chk(16'(awake_ind_ff), 16'h1);
        wait_radio(1'b0, 20);
        chk(16'(cnt >= TK - 1 && cnt <= TK + 2), 16'h1);
        wait_radio(1'b1, 30);
        send_byte();
        cyc(10);
        send_byte();
        cyc(10);
        rf_rx_activity = 1'b1;
        cyc(1);
        rf_rx_activity = 1'b0;
        wait_radio(1'b0, 40);
        chk(16'(cnt >= 5 * TK && cnt <= 5 * TK + 6), 16'h1);
        chk(16'(awake_ind_ff), 16'h0);
        $display("done cyclic");
        want_sleep = 1'b1;
        sleep_mode_select = 4'h5;
        wait_radio(1'b1, 40);
        wait_radio(1'b0, 30);
        wait_radio(1'b1, 30);
        chk(16'(cnt >= 3 * TK && cnt <= 3 * TK + 3), 16'h1);
        wait_radio(1'b0, 20);
        want_sleep = 1'b0;
        wait_radio(1'b1, 6);
        cyc(40);
        chk(16'(radio_on_ff), 16'h1);
        $display("done cyclic pin");
        wake_time = 16'h0002;
        sleep_mode_select = 4'h8;
        wait_radio(1'b0, 40);
        chk(16'(synced_ff), 16'h0);
        chk(16'(host_accept_ff), 16'h0);
        chk(16'(awake_ind_ff), 16'h0);
        chk(16'(cts_n_ff), 16'h1);
        send_sync(16'h0006, 16'h0004);
        cyc(2);
        chk(16'(synced_ff), 16'h0);
        wait_radio(1'b1, 30);
        chk(16'(awake_ind_ff), 16'h1);
        n_relay = 0;
        send_sync(16'h0006, 16'h0004);
        cyc(3);
        chk(16'(synced_ff), 16'h1);
        chk(synced_sleep_time_query_ff, 16'h0006);
        chk(synced_wake_time_query_ff, 16'h0004);
        chk(16'(n_relay), 16'h1);
        wait_radio(1'b0, 30);
        wait_radio(1'b1, 40);
        chk(16'(cnt >= 6 * TK && cnt <= 6 * TK + 3), 16'h1);
        sleep_coordinator = 1'b1;
        sleep_period = 16'h0002;
        settings_changed = 1'b1;
        cyc(1);
        settings_changed = 1'b0;
        cyc(2);
        chk(synced_sleep_time_query_ff, 16'h0002);
        chk(synced_wake_time_query_ff, 16'h0002);
        wait_radio(1'b0, 60);
        wait_radio(1'b1, 60);
        cyc(3);
        n_tx = 0;
        wait_radio(1'b0, 60);
        wait_radio(1'b1, 60);
        cyc(3);
        chk(16'(n_tx), 16'h1);
        $display("done sync cyclic");
        sleep_coordinator = 1'b0;
        sleep_mode_select = 4'h7;
        cyc(20);
        send_sync(16'h0002, 16'h0002);
        cyc(4);
        n_tx = 0;
        join_request = 1'b1;
        cyc(1);
        join_request = 1'b0;
        cyc(3);
        chk(16'(n_tx), 16'h1);
        repeat (64) begin
            cyc(1);
            if (data_tx_ok_ff === 1'b1) ok_hi++;
            else ok_lo++;
        end
        chk(16'(ok_hi > 0 && ok_lo > 0), 16'h1);
        $display("done support");
        final_report();
    end
endmodule

bind smc_top smc_top_monitor i_mon (.ref_clk, .sys_rst, .sleep_mode_select,
    .doze_request_pin, .cts_flow_enable, .poll_enable, .tx_busy, .rx_busy,
    .radio_on_ff, .awake_ind_ff, .cts_n_ff, .poll_req_ff, .sync_tx_ff);
